// ==== pam_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pam_defines.svh"
// Notes on behaviour
// - activity in low-power returns to on
// - any activity resets all three timers
// - per-device and per-range read/write masks
// - bus hold maskable as activity
// - external input edges maskable, edge selectable
// - flag enable records flags
// - flag bits mirror mask bits
// - activity raises smi unless masked
// - disable auto on blocks hardware return except from the smm latch hold
// - smm latch holds activity until smi ends
// - smi may trigger activity, not recursive
// - any activity, bridge irq included, leaves deep sleep
// - serial links carry events once enabled
// - bridge irq activity raises no smi
// - idle timers time out with status bits and irq, not smi
// - inputs debounce and edge configurable
module pam_monitor import pam_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] dev_access,
  input wire logic [5:0] range_rd,
  input wire logic [5:0] range_wr,
  input wire logic bus_hold,
  input wire logic [4:0] ext_in,
  input wire logic bridge_irq_act,
  input wire logic other_smi,
  input wire logic smi_active_n,
  input wire logic serial_link_enable,
  output logic activity_smi,
  output logic [2:0] power_mode,
  output logic irq
);
  // ==========================================================
  // registers
  logic [7:0] activity_option_control;
  logic [15:0] activity_mask_devices;
  logic [15:0] activity_mask_inputs;
  logic [15:0] activity_flags_devices;
  logic [15:0] activity_flags_inputs;
  logic [9:0] edge_detect_control;
  logic [4:0] debounce_en;
  logic [31:0] timer_limit;
  logic [`PAM_ST_W-1:0] status;
  logic [`PAM_ST_W-1:0] irq_mask;
  pam_mode_t mode;
  logic [31:0] doze_idle_timer;
  logic [31:0] sleep_idle_timer;
  logic [31:0] suspend_idle_timer;
  logic pa_latched;
  logic smi_from_pa;

  function automatic logic is_off(input logic [3:0] a, input logic [3:0] off);
    is_off = (a == off);
  endfunction

  // ==========================================================
  // bus slave: one wait cycle per access
  logic ack;
  wire logic req = (avs_read | avs_write) & ~ack;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~req;
    end
  end
  wire logic wr_go = avs_write & ack;

  // ==========================================================
  // external inputs: debounce and edge select
  logic [4:0] ext_prev;
  logic [4:0] ext_filt;
  logic [4:0] ext_edge;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_in
      logic [7:0] cnt;
      logic raw_q;
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          raw_q <= 1'b0;
          cnt <= 8'h00;
          ext_filt[gi] <= 1'b0;
        end else begin
          raw_q <= ext_in[gi];
          if (!debounce_en[gi]) begin
            ext_filt[gi] <= raw_q;
            cnt <= 8'h00;
          end else if (raw_q == ext_filt[gi]) begin
            cnt <= 8'h00;
          end else if (cnt == 8'(`PAM_DEBOUNCE_CYC - 1)) begin
            ext_filt[gi] <= raw_q;
            cnt <= 8'h00;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
      end
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          ext_prev[gi] <= 1'b0;
        end else begin
          ext_prev[gi] <= ext_filt[gi];
        end
      end
      // rising on bit 2i, falling on bit 2i+1
      assign ext_edge[gi] = (edge_detect_control[2*gi] & ext_filt[gi] & ~ext_prev[gi]) |
                            (edge_detect_control[2*gi+1] & ~ext_filt[gi] & ext_prev[gi]);
    end
  endgenerate

  // ==========================================================
  // activity gathering
  // devices: [7:0] accesses, [13:8] ranges, [14] hold, [15] smi
  logic [15:0] dev_src;
  logic [15:0] in_src;
  logic smi_event;
  assign smi_event = other_smi & ~smi_from_pa;
  assign dev_src[7:0] = dev_access & ~activity_mask_devices[7:0];
  generate
    for (gi = 0; gi < 6; gi++) begin : g_rng
      // mask bit set blocks; read masked by high half of input reg
      assign dev_src[8+gi] = ~activity_mask_devices[8+gi] &
        ((range_rd[gi] & ~activity_mask_inputs[8+gi]) |
         (range_wr[gi] & ~activity_mask_inputs[10+(gi%6)] & 1'b1));
    end
  endgenerate
  assign dev_src[14] = bus_hold & ~activity_mask_devices[14];
  assign dev_src[15] = smi_event & ~activity_option_control[`PAM_OPT_SMI_TO_ACT];
  assign in_src[4:0] = ext_edge & ~activity_mask_inputs[4:0];
  assign in_src[5] = bridge_irq_act & serial_link_enable & ~activity_mask_inputs[5];
  assign in_src[15:6] = 10'h000;
  wire logic local_pa = |dev_src | (|in_src[4:0]);
  wire logic any_pa = local_pa | in_src[5];
  wire logic in_smm = ~smi_active_n;
  wire logic hold_pa = pa_latched & in_smm;
  wire logic pa_eff = any_pa | hold_pa;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_latched <= 1'b0;
    end else if (!in_smm) begin
      pa_latched <= 1'b0;
    end else if (any_pa & activity_option_control[`PAM_OPT_SMM_LATCH]) begin
      pa_latched <= 1'b1;
    end
  end

  // ==========================================================
  // flags, hardware set wins over write-one clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      activity_flags_devices <= 16'h0000;
      activity_flags_inputs <= 16'h0000;
    end else begin
      activity_flags_devices <= (activity_flags_devices &
        ~((wr_go && is_off(avs_address, `PAM_OFF_FLAG_DEV)) ? avs_writedata[15:0] : 16'h0000)) |
        (activity_option_control[`PAM_OPT_FLAG_EN] ? dev_src : 16'h0000);
      activity_flags_inputs <= (activity_flags_inputs &
        ~((wr_go && is_off(avs_address, `PAM_OFF_FLAG_IN)) ? avs_writedata[15:0] : 16'h0000)) |
        (activity_option_control[`PAM_OPT_FLAG_EN] ? in_src : 16'h0000);
    end
  end

  // ==========================================================
  // activity smi, not for bridge irq activity
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      activity_smi <= 1'b0;
      smi_from_pa <= 1'b0;
    end else begin
      activity_smi <= local_pa & ~activity_option_control[`PAM_OPT_SMI_MASK];
      smi_from_pa <= local_pa & ~activity_option_control[`PAM_OPT_SMI_MASK];
    end
  end

  // ==========================================================
  // idle timers
  // at or beyond limit, so a limit lowered under a running count still expires
  wire logic doze_to = (doze_idle_timer >= timer_limit);
  wire logic sleep_to = (sleep_idle_timer >= {timer_limit[30:0], 1'b0});
  wire logic susp_to = (suspend_idle_timer >= {timer_limit[29:0], 2'b00});
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      doze_idle_timer <= 32'h0;
      sleep_idle_timer <= 32'h0;
      suspend_idle_timer <= 32'h0;
    end else if (pa_eff) begin
      doze_idle_timer <= 32'h0;
      sleep_idle_timer <= 32'h0;
      suspend_idle_timer <= 32'h0;
    end else begin
      if (!doze_to) doze_idle_timer <= doze_idle_timer + 32'h1;
      if (!sleep_to) sleep_idle_timer <= sleep_idle_timer + 32'h1;
      if (!susp_to) suspend_idle_timer <= suspend_idle_timer + 32'h1;
    end
  end
  logic doze_q, sleep_q, susp_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      doze_q <= 1'b0;
      sleep_q <= 1'b0;
      susp_q <= 1'b0;
    end else begin
      doze_q <= doze_to;
      sleep_q <= sleep_to;
      susp_q <= susp_to;
    end
  end

  // ==========================================================
  // mode, software writes enter low power
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= PAM_ON;
    end else if (hold_pa) begin
      mode <= PAM_ON;
    end else if (any_pa && !activity_option_control[`PAM_OPT_NO_AUTO_ON]) begin
      mode <= PAM_ON;
    end else if (wr_go && is_off(avs_address, `PAM_OFF_MODE)) begin
      case (avs_writedata[1:0])
        2'b00: mode <= PAM_ON;
        2'b01: mode <= PAM_DOZE;
        2'b10: mode <= PAM_SLEEP;
        default: mode <= PAM_DEEP;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_mode <= 3'h0;
    end else begin
      power_mode <= mode;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      activity_option_control <= `PAM_OPTION_RST;
      activity_mask_devices <= `PAM_MASK_RST;
      activity_mask_inputs <= `PAM_MASK_RST;
      edge_detect_control <= 10'h155;
      debounce_en <= 5'h00;
      timer_limit <= `PAM_TIMER_RST;
      irq_mask <= '1;
    end else if (wr_go) begin
      if (is_off(avs_address, `PAM_OFF_OPTION)) begin
        activity_option_control <= avs_writedata[7:0];
      end else if (is_off(avs_address, `PAM_OFF_MASK_DEV)) begin
        activity_mask_devices <= avs_writedata[15:0];
      end else if (is_off(avs_address, `PAM_OFF_MASK_IN)) begin
        activity_mask_inputs <= avs_writedata[15:0];
      end else if (is_off(avs_address, `PAM_OFF_EDGE)) begin
        edge_detect_control <= avs_writedata[9:0];
        debounce_en <= avs_writedata[20:16];
      end else if (is_off(avs_address, `PAM_OFF_TIMER)) begin
        timer_limit <= avs_writedata;
      end else if (is_off(avs_address, `PAM_OFF_IRQ_MASK)) begin
        irq_mask <= avs_writedata[`PAM_ST_W-1:0];
      end
    end
  end

  // ==========================================================
  // interrupt status
  logic [`PAM_ST_W-1:0] ev;
  assign ev = {susp_to & ~susp_q, sleep_to & ~sleep_q, doze_to & ~doze_q,
               activity_smi, any_pa};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status <= (status & ~((wr_go && is_off(avs_address, `PAM_OFF_STATUS)) ?
                 avs_writedata[`PAM_ST_W-1:0] : '0)) | ev;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & ~irq_mask);
    end
  end

  // ==========================================================
  // read data
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0;
    end else if (req && avs_read) begin
      if (is_off(avs_address, `PAM_OFF_OPTION)) avs_readdata <= {24'h0, activity_option_control};
      else if (is_off(avs_address, `PAM_OFF_MASK_DEV)) avs_readdata <= {16'h0, activity_mask_devices};
      else if (is_off(avs_address, `PAM_OFF_MASK_IN)) avs_readdata <= {16'h0, activity_mask_inputs};
      else if (is_off(avs_address, `PAM_OFF_FLAG_DEV)) avs_readdata <= {16'h0, activity_flags_devices};
      else if (is_off(avs_address, `PAM_OFF_FLAG_IN)) avs_readdata <= {16'h0, activity_flags_inputs};
      else if (is_off(avs_address, `PAM_OFF_EDGE)) avs_readdata <= {11'h0, debounce_en, 6'h0, edge_detect_control};
      else if (is_off(avs_address, `PAM_OFF_TIMER)) avs_readdata <= timer_limit;
      else if (is_off(avs_address, `PAM_OFF_STATUS)) avs_readdata <= {27'h0, status};
      else if (is_off(avs_address, `PAM_OFF_IRQ_MASK)) avs_readdata <= {27'h0, irq_mask};
      else if (is_off(avs_address, `PAM_OFF_MODE)) avs_readdata <= {29'h0, mode};
      else avs_readdata <= 32'h0;
    end
  end

  // ==========================================================
  a_timers_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    any_pa |=> doze_idle_timer == 32'h0 && suspend_idle_timer == 32'h0) else $error("timers not reset");
  a_auto_on: assert property (@(posedge core_clk) disable iff (!rst_n)
    any_pa && !activity_option_control[`PAM_OPT_NO_AUTO_ON] |=> mode == PAM_ON) else $error("no return to on");
  a_no_auto_on: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode != PAM_ON && activity_option_control[`PAM_OPT_NO_AUTO_ON] && !hold_pa &&
    !(wr_go && is_off(avs_address, `PAM_OFF_MODE)) |=> $stable(mode)) else $error("auto on while disabled");
  a_smi_pa: assert property (@(posedge core_clk) disable iff (!rst_n)
    local_pa && !activity_option_control[`PAM_OPT_SMI_MASK] |=> activity_smi) else $error("missing smi");
  a_bridge_nosmi: assert property (@(posedge core_clk) disable iff (!rst_n)
    !local_pa |=> !activity_smi) else $error("smi without local activity");
  a_flag_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    !activity_option_control[`PAM_OPT_FLAG_EN] && activity_flags_devices == 16'h0 |=>
    activity_flags_devices == 16'h0) else $error("flag while disabled");
  a_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    activity_option_control[`PAM_OPT_FLAG_EN] && dev_src[14] |=> activity_flags_devices[14]) else $error("flag lost");
  a_masked_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    activity_mask_devices[14] |-> !dev_src[14]) else $error("masked hold counted");
  a_smm_latch: assert property (@(posedge core_clk) disable iff (!rst_n)
    hold_pa |=> mode == PAM_ON && doze_idle_timer == 32'h0) else $error("latch not held");
  a_no_recursion: assert property (@(posedge core_clk) disable iff (!rst_n)
    smi_from_pa |-> !dev_src[15]) else $error("recursive smi");
  c_wake: cover property (@(posedge core_clk) disable iff (!rst_n) mode == PAM_DEEP ##1 mode == PAM_ON);
  c_smi: cover property (@(posedge core_clk) disable iff (!rst_n) activity_smi);
  c_latch: cover property (@(posedge core_clk) disable iff (!rst_n) hold_pa ##1 !in_smm);
endmodule
`default_nettype wire

// ==== pam_defines.svh ====
`ifndef PAM_DEFINES_SVH
`define PAM_DEFINES_SVH
// register word offsets
`define PAM_OFF_OPTION 4'h0
`define PAM_OFF_MASK_DEV 4'h1
`define PAM_OFF_MASK_IN 4'h2
`define PAM_OFF_FLAG_DEV 4'h3
`define PAM_OFF_FLAG_IN 4'h4
`define PAM_OFF_EDGE 4'h5
`define PAM_OFF_TIMER 4'h6
`define PAM_OFF_STATUS 4'h7
`define PAM_OFF_IRQ_MASK 4'h8
`define PAM_OFF_MODE 4'h9
// option bits
`define PAM_OPT_FLAG_EN 0
`define PAM_OPT_SMI_MASK 1
`define PAM_OPT_SMM_LATCH 2
`define PAM_OPT_NO_AUTO_ON 3
`define PAM_OPT_SMI_TO_ACT 4
// reset values
`define PAM_OPTION_RST 8'h13
`define PAM_MASK_RST 16'hFFFF
`define PAM_TIMER_RST 32'h0000FFFF
// status bits
`define PAM_ST_ACT 0
`define PAM_ST_SMI 1
`define PAM_ST_DOZE 2
`define PAM_ST_SLEEP 3
`define PAM_ST_SUSP 4
`define PAM_ST_W 5
// debounce
`define PAM_DEBOUNCE_NS 64
`define PAM_DEBOUNCE_CYC ((`PAM_DEBOUNCE_NS + 3) / 4)
`endif

// ==== pam_pkg.sv ====
package pam_pkg;
  typedef enum logic [2:0] {
    PAM_ON = 3'b000,
    PAM_DOZE = 3'b001,
    PAM_SLEEP = 3'b010,
    PAM_DEEP = 3'b011
  } pam_mode_t;
endpackage

// ==== pam_bridge_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bridge side: irq masking and link gating
module pam_bridge_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] bridge_power_control,
  input wire logic [15:0] irq_lines,
  input wire logic [15:0] irq_mask,
  output logic bridge_irq_act,
  output logic bridge_smi,
  output logic serial_link_enable
);
  // bit 0 carries nmi, bit 2 is the cascade line and never reports
  localparam logic [15:0] PAM_IRQ_VALID = 16'hFFFB;
  logic hit;
  assign serial_link_enable = bridge_power_control[0];
  assign hit = |(irq_lines & ~irq_mask & PAM_IRQ_VALID);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bridge_irq_act <= 1'b0;
      bridge_smi <= 1'b0;
    end else begin
      bridge_irq_act <= hit & serial_link_enable;
      bridge_smi <= hit & serial_link_enable & bridge_power_control[2];
    end
  end
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pam_defines.svh"
module testbench import pam_pkg::*;;
  logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, bus_hold, tb_smi;
  logic bridge_irq_act, bridge_smi, smi_active_n, link_en, activity_smi, irq;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, e;
  logic [7:0] dev_access, bpc, v;
  logic [5:0] range_rd, range_wr;
  logic [4:0] ext_in;
  logic [2:0] power_mode;
  logic [15:0] irq_lines, irq_mask;
  int num_errors, n_tests, smi_cnt, i, c;
  pam_monitor dut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dev_access(dev_access), .range_rd(range_rd), .range_wr(range_wr), .bus_hold(bus_hold),
    .ext_in(ext_in), .bridge_irq_act(bridge_irq_act), .other_smi(bridge_smi | tb_smi),
    .smi_active_n(smi_active_n), .serial_link_enable(link_en),
    .activity_smi(activity_smi), .power_mode(power_mode), .irq(irq));
  pam_bridge_model bridge (.core_clk(core_clk), .rst_n(rst_n), .bridge_power_control(bpc),
    .irq_lines(irq_lines), .irq_mask(irq_mask), .bridge_irq_act(bridge_irq_act),
    .bridge_smi(bridge_smi), .serial_link_enable(link_en));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (activity_smi === 1'b1) smi_cnt <= smi_cnt + 1;
  end
  // ==========================================
  // bus cycles and checks
  task automatic wrap_up();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      $display("Error %s expected %h seen %h", nm, x, g);
      num_errors++;
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      num_errors++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdm(input string nm, input logic [3:0] a, input logic [31:0] m,
                     input logic [31:0] x);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, x, r & m);
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one-cycle pulse on a chosen activity source
  task automatic pulse(input int k, input logic [15:0] p);
    case (k)
      0: dev_access <= p[7:0];
      1: irq_lines <= p;
      2: tb_smi <= p[0];
      3: range_rd <= p[5:0];
      4: range_wr <= p[5:0];
      default: bus_hold <= p[0];
    endcase
    @(posedge core_clk);
    {dev_access, irq_lines, tb_smi, range_rd, range_wr, bus_hold} <= '0;
  endtask
  // bounded poll of the mode (s=0) or the interrupt line (s=1)
  task automatic wait_for(input logic s, input logic [2:0] x, input int lim);
    logic [2:0] g;
    int n;
    n = 0;
    g = s ? {2'b0, irq} : power_mode;
    while (g !== x && n < lim) begin
      @(posedge core_clk);
      n++;
      g = s ? {2'b0, irq} : power_mode;
    end
    chk(s ? "irq" : "power_mode", {29'h0, x}, {29'h0, g});
  endtask
  function automatic logic [31:0] exp_flag(input logic [15:0] m, input logic [15:0] a,
                                           input logic en);
    return en ? {16'h0, a & ~m} : 32'h0;
  endfunction
  task automatic setup(input logic [7:0] o, input logic [15:0] md, input logic [15:0] mi);
    wr(`PAM_OFF_OPTION, {24'h0, o});
    wr(`PAM_OFF_MASK_DEV, {16'h0, md});
    wr(`PAM_OFF_MASK_IN, {16'h0, mi});
    wr(`PAM_OFF_FLAG_DEV, 32'hFFFF);
    wr(`PAM_OFF_FLAG_IN, 32'hFFFF);
    wr(`PAM_OFF_STATUS, 32'h1F);
    wr(`PAM_OFF_MODE, {29'h0, PAM_DOZE});
    wait_for(1'b0, PAM_DOZE, 4);
  endtask
  // ==========================================
  // main sequence
  initial begin
    {rst_n, avs_read, avs_write, bus_hold, tb_smi, range_rd, range_wr, ext_in} = '0;
    {avs_address, avs_writedata, dev_access, bpc, irq_lines} = '0;
    smi_active_n = 1'b1;
    irq_mask = 16'hFFFF;
    {num_errors, n_tests, smi_cnt} = '0;
    c = $urandom(32'h7f779fea);
    hold(2);
    rst_n <= 1'b1;
    rdm("option", `PAM_OFF_OPTION, 32'hFF, 32'h13);
    rdm("mask_dev", `PAM_OFF_MASK_DEV, 32'hFFFF, 32'hFFFF);
    rdm("edge", `PAM_OFF_EDGE, 32'h1FFFFF, 32'h155);
    rdm("timer", `PAM_OFF_TIMER, 32'hFFFFFFFF, 32'hFFFF);
    wr(4'hF, 32'hFFFFFFFF);
    rdm("hole", 4'hF, 32'hFFFFFFFF, 32'h0);
    for (i = 0; i < 8; i++) begin
      v = 8'($urandom) & ~(8'h1 << i);
      setup(8'h13, ~(16'h1 << i), 16'hFFFF);
      c = smi_cnt;
      pulse(0, {8'h0, v});
      hold(8);
      wait_for(1'b0, PAM_DOZE, 0);
      pulse(0, {8'h0, v | (8'h1 << i)});
      wait_for(1'b0, PAM_ON, 8);
      e = exp_flag(~(16'h1 << i), {8'h0, v} | (16'h1 << i), 1'b1);
      rdm("flags_dev", `PAM_OFF_FLAG_DEV, 32'hFFFF, e);
      chk("smi_count", c, smi_cnt);
    end
    setup(8'h13, ~16'h0100, ~16'h0100);
    pulse(4, 16'h1);
    hold(8);
    wait_for(1'b0, PAM_DOZE, 0);
    pulse(3, 16'h1);
    wait_for(1'b0, PAM_ON, 8);
    setup(8'h13, ~16'h4000, 16'hFFFF);
    pulse(5, 16'h1);
    wait_for(1'b0, PAM_ON, 8);
    rdm("flags_dev", `PAM_OFF_FLAG_DEV, 32'hFFFF, 32'h4000);
    setup(8'h10, 16'hFFFE, 16'hFFFF);
    c = smi_cnt;
    pulse(0, 16'h1);
    wait_for(1'b0, PAM_ON, 8);
    hold(4);
    chk("smi_count", c + 1, smi_cnt);
    rdm("flags_dev", `PAM_OFF_FLAG_DEV, 32'hFFFF, exp_flag(16'hFFFE, 16'h1, 1'b0));
    setup(8'h1B, 16'hFFFE, 16'hFFFF);
    pulse(0, 16'h1);
    hold(8);
    wait_for(1'b0, PAM_DOZE, 0);
    for (i = 0; i < 5; i++) begin
      setup(8'h13, 16'hFFFF, ~(16'h1 << i));
      wr(`PAM_OFF_EDGE, 32'h2 << (2 * i));
      ext_in <= 5'h1 << i;
      hold(8);
      wait_for(1'b0, PAM_DOZE, 0);
      ext_in <= 5'h0;
      wait_for(1'b0, PAM_ON, 8);
      rdm("flags_in", `PAM_OFF_FLAG_IN, 32'h1F, exp_flag(~(16'h1 << i), 16'h1F, 1'b1));
    end
    setup(8'h13, 16'hFFFF, 16'hFFEF);
    wr(`PAM_OFF_EDGE, 32'h00100100);
    ext_in <= 5'h10;
    hold(2);
    ext_in <= 5'h0;
    hold(24);
    wait_for(1'b0, PAM_DOZE, 0);
    ext_in <= 5'h10;
    wait_for(1'b0, PAM_ON, 30);
    ext_in <= 5'h0;
    setup(8'h11, 16'hFFFF, 16'hFFDF);
    irq_mask <= 16'hFFDF;
    pulse(1, 16'h0020);
    hold(8);
    wait_for(1'b0, PAM_DOZE, 0);
    bpc <= 8'h01;
    c = smi_cnt;
    pulse(1, 16'h0040);
    hold(8);
    wait_for(1'b0, PAM_DOZE, 0);
    pulse(1, 16'h0020);
    wait_for(1'b0, PAM_ON, 8);
    hold(4);
    chk("smi_count", c, smi_cnt);
    setup(8'h11, 16'h7FFF, 16'hFFFF);
    wr(`PAM_OFF_MODE, {29'h0, PAM_DEEP});
    wait_for(1'b0, PAM_DEEP, 4);
    pulse(2, 16'h1);
    hold(8);
    wait_for(1'b0, PAM_DEEP, 0);
    wr(`PAM_OFF_OPTION, 32'h01);
    pulse(2, 16'h1);
    wait_for(1'b0, PAM_ON, 8);
    setup(8'h01, 16'h7FFE, 16'hFFFF);
    c = smi_cnt;
    pulse(0, 16'h1);
    hold(20);
    chk("smi_count", c + 1, smi_cnt);
    setup(8'h17, 16'hFFFE, 16'hFFFF);
    smi_active_n <= 1'b0;
    pulse(0, 16'h1);
    wait_for(1'b0, PAM_ON, 8);
    wr(`PAM_OFF_MODE, {29'h0, PAM_DOZE});
    hold(4);
    wait_for(1'b0, PAM_ON, 0);
    smi_active_n <= 1'b1;
    wr(`PAM_OFF_MODE, {29'h0, PAM_DOZE});
    wait_for(1'b0, PAM_DOZE, 4);
    wr(`PAM_OFF_IRQ_MASK, 32'hFFFE);
    wr(`PAM_OFF_STATUS, 32'h1F);
    wait_for(1'b1, 3'h0, 4);
    pulse(0, 16'h1);
    wait_for(1'b1, 3'h1, 8);
    wr(`PAM_OFF_IRQ_MASK, 32'hFFFF);
    wait_for(1'b1, 3'h0, 4);
    wr(`PAM_OFF_IRQ_MASK, 32'hFFFE);
    wait_for(1'b1, 3'h1, 4);
    wr(`PAM_OFF_STATUS, 32'h1);
    wait_for(1'b1, 3'h0, 4);
    wr(`PAM_OFF_TIMER, 32'h8);
    setup(8'h13, 16'hFFFE, 16'hFFFF);
    for (i = 0; i < 12; i++) begin
      pulse(0, 16'h1);
      hold(2);
    end
    rdm("status", `PAM_OFF_STATUS, 32'h1C, 32'h0);
    hold(60);
    rdm("status", `PAM_OFF_STATUS, 32'h1C, 32'h1C);
    wrap_up();
  end
endmodule
`default_nettype wire
